// ---- logic/tmr2_fall_detect.sv ----
`timescale 1ns/1ns
// Three-stage synchroniser with falling-edge detection on the agreeing stages.
module tmr2_fall_detect
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  // Pin and event
  input  wire logic i_pin,
  output logic      o_fall
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       level_r;
  logic       level_nxt;
  logic       fall_nxt;

  always_comb
  begin
    sync_nxt  = {sync_r[1:0], i_pin};
    level_nxt = level_r;
    fall_nxt  = 1'b0;
    if (sync_r[2] == sync_r[1])
    begin
      level_nxt = sync_r[2];
      fall_nxt  = level_r & ~sync_r[2]; // R15
    end
  end

  // The pins idle high, so the filtered level starts high to avoid a false edge.
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sync_r  <= 3'h7;
      level_r <= 1'b1;
      o_fall  <= 1'b0;
    end
    else
    begin
      sync_r  <= sync_nxt;
      level_r <= level_nxt;
      o_fall  <= fall_nxt;
    end
  end
endmodule

// ---- logic/tmr2_timer.sv ----
`timescale 1ns/1ns
`include "tmr2_regs.svh"
// Function
// R1: Overflow flag sets on rollover only when neither baud select is set.
// R2: External-event flag sets when a trigger edge causes capture or reload.
// R3: Event flag raises timer interrupt unless up/down counting is enabled.
// R4: Receive baud select routes this timer's overflow to serial receive clock.
// R5: Transmit baud select routes this timer's overflow to serial transmit clock.
// R6: Trigger enable gates trigger-pin edges; ignored while clocking the serial port.
// R7: Run control starts and stops counting.
// R8: Count source selects internal clock or falling edges on the count pin.
// R9: Any baud select forces auto-reload and ignores capture/reload select.
// R10: Capture/reload select picks reload or capture on trigger edges.
// R11: Control register resets to zero and supports single-bit writes.
// R12: Mode register at C9h holds clock-out enable and up/down enable; here it is decoded at byte address 324h, not C9h.
// R13: Software writes no ones into reserved bits; they read as zero here.
// R14: Sixteen-bit counter with sixteen-bit capture/reload register.
// R15: Pin falling edges found by comparing successive core-clock samples.
module tmr2_timer
  import tmr2_pkg::*;
#(
  parameter int unsigned WIDTH = 16
)
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Pins
  input  wire logic        i_count_pin,
  input  wire logic        i_trigger_pin,
  output logic             o_count_pin_out,
  output logic             o_count_pin_oe,
  // Serial port baud clocks
  input  wire logic        i_timer1_overflow,
  output logic             o_rx_baud_tick,
  output logic             o_tx_baud_tick,
  // Interrupts
  output logic             o_timer_irq,
  output logic             o_irq
);
  logic [7:0]       ctrl_r;
  logic [7:0]       ctrl_nxt;
  logic [1:0]       mode_r;
  logic [1:0]       mode_nxt;
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic [WIDTH-1:0] reload_r;
  logic [WIDTH-1:0] reload_nxt;
  logic [2:0]       irq_stat_r;
  logic [2:0]       irq_stat_nxt;
  logic [2:0]       irq_mask_r;
  logic [2:0]       irq_mask_nxt;
  logic [31:0]      prdata_nxt;
  logic             ovf_tick_r;
  logic             ovf_tick_nxt;
  logic             clkout_r;
  logic             clkout_nxt;
  logic [2:0]       dir_sync_r;
  logic [2:0]       dir_sync_nxt;
  logic             count_fall;
  logic             trig_fall;
  logic             trigger_pin_level;
  logic             wr_en;
  logic             rd_en;
  logic             baud_mode;
  logic             tick;
  logic             overflow;
  logic             underflow;
  logic             trig_act;
  logic             count_down;
  tmr2_action_t     act;

  tmr2_fall_detect u_count_edge
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_count_pin),
    .o_fall    (count_fall)
  );

  tmr2_fall_detect u_trig_edge
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_trigger_pin),
    .o_fall    (trig_fall)
  );

  // Zero wait states: every access completes in its first access cycle.
  assign o_pready  = 1'b1;
  assign wr_en     = i_psel & i_penable & i_pwrite;
  assign rd_en     = i_psel & i_penable & ~i_pwrite;
  assign baud_mode = ctrl_r[`TMR2_BIT_RXSEL] | ctrl_r[`TMR2_BIT_TXSEL];

  // The up/down direction comes from the trigger pin level in up/down mode.
  // The pin is asynchronous, so its level is taken only after three flip-flops.
  assign trigger_pin_level = dir_sync_r[2];

  always_comb
  begin
    o_pslverr = 1'b0;
    if (i_psel && i_penable)
    begin
      case (i_paddr)
        `TMR2_ADDR_CONTROL, `TMR2_ADDR_MODE_BYTE, `TMR2_ADDR_COUNT,
        `TMR2_ADDR_RELOAD, `TMR2_ADDR_IRQ_STATUS, `TMR2_ADDR_IRQ_MASK:
          o_pslverr = 1'b0;
        default:
          o_pslverr = 1'b1;
      endcase
    end
  end

  always_comb
  begin
    tick       = 1'b0;
    overflow   = 1'b0;
    underflow  = 1'b0;
    trig_act   = 1'b0;
    act        = TMR2_ACT_NONE;
    count_down = mode_r[`TMR2_BIT_UPDOWN] & ~baud_mode & ~ctrl_r[`TMR2_BIT_CAPREL];
    count_nxt  = count_r;
    reload_nxt = reload_r;
    if (ctrl_r[`TMR2_BIT_RUN]) // R7
    begin
      tick = ctrl_r[`TMR2_BIT_SRC] ? count_fall : 1'b1; // R8
    end
    if (tick)
    begin
      if (count_down && !trigger_pin_level)
      begin
        underflow = (count_r == reload_r);
        count_nxt = underflow ? {WIDTH{1'b1}} : count_r - 1'b1;
      end
      else
      begin
        overflow  = &count_r; // R14
        count_nxt = count_r + 1'b1;
      end
    end
    // Trigger edges act only when enabled, not clocking the serial port and not in up/down mode.
    if (ctrl_r[`TMR2_BIT_TRIGEN] && trig_fall && !baud_mode && !mode_r[`TMR2_BIT_UPDOWN]) // R6
    begin
      trig_act = 1'b1;
      act = ctrl_r[`TMR2_BIT_CAPREL] ? TMR2_ACT_CAPTURE : TMR2_ACT_RELOAD; // R10
    end
    if (overflow && (baud_mode || !ctrl_r[`TMR2_BIT_CAPREL])) // R9
    begin
      act = TMR2_ACT_RELOAD;
    end
    case (act)
      TMR2_ACT_RELOAD:
        count_nxt = reload_r; // R14
      TMR2_ACT_CAPTURE:
        reload_nxt = count_r; // R14
      default:
        count_nxt = count_nxt;
    endcase
    if (wr_en && i_pstrb[0] && i_paddr == `TMR2_ADDR_COUNT)
    begin
      count_nxt = i_pwdata[WIDTH-1:0];
    end
    if (wr_en && i_pstrb[0] && i_paddr == `TMR2_ADDR_RELOAD)
    begin
      reload_nxt = i_pwdata[WIDTH-1:0];
    end
  end

  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    mode_nxt     = mode_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    // A byte write with one changed bit serves as the single-bit write.
    if (wr_en && i_pstrb[0] && i_paddr == `TMR2_ADDR_CONTROL)
    begin
      ctrl_nxt = i_pwdata[7:0]; // R11
    end
    if (wr_en && i_pstrb[0] && i_paddr == `TMR2_ADDR_MODE_BYTE)
    begin
      mode_nxt = i_pwdata[1:0]; // R12
    end
    if (wr_en && i_pstrb[0] && i_paddr == `TMR2_ADDR_IRQ_MASK)
    begin
      irq_mask_nxt = i_pwdata[2:0];
    end
    if (rd_en && i_paddr == `TMR2_ADDR_IRQ_STATUS)
    begin
      irq_stat_nxt = 3'h0;
    end
    // Hardware sets are applied last so they win over a same-cycle clear.
    if ((overflow || underflow) && !baud_mode)
    begin
      ctrl_nxt[`TMR2_BIT_OVF]      = 1'b1; // R1
      irq_stat_nxt[`TMR2_IRQ_OVF] = 1'b1;
    end
    if (trig_act)
    begin
      ctrl_nxt[`TMR2_BIT_EXF]      = 1'b1; // R2
      irq_stat_nxt[`TMR2_IRQ_EXF] = 1'b1;
    end
    if (act == TMR2_ACT_CAPTURE)
    begin
      irq_stat_nxt[`TMR2_IRQ_CAPTURE] = 1'b1;
    end
    dir_sync_nxt = {dir_sync_r[1:0], i_trigger_pin};
    ovf_tick_nxt = overflow | underflow;
    clkout_nxt   = clkout_r;
    if (overflow && mode_r[`TMR2_BIT_CLKOUT] && !ctrl_r[`TMR2_BIT_SRC])
    begin
      clkout_nxt = ~clkout_r;
    end
  end

  always_comb
  begin
    prdata_nxt = 32'h0;
    case (i_paddr)
      `TMR2_ADDR_CONTROL:
        prdata_nxt[7:0] = ctrl_r;
      `TMR2_ADDR_MODE_BYTE:
        prdata_nxt[1:0] = mode_r; // R13
      `TMR2_ADDR_COUNT:
        prdata_nxt[WIDTH-1:0] = count_r;
      `TMR2_ADDR_RELOAD:
        prdata_nxt[WIDTH-1:0] = reload_r;
      `TMR2_ADDR_IRQ_STATUS:
        prdata_nxt[2:0] = irq_stat_r;
      `TMR2_ADDR_IRQ_MASK:
        prdata_nxt[2:0] = irq_mask_r;
      default:
        prdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_r     <= `TMR2_CONTROL_RESET;
      mode_r     <= `TMR2_MODE_RESET;
      count_r    <= '0;
      reload_r   <= '0;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      ovf_tick_r <= 1'b0;
      clkout_r   <= 1'b0;
      dir_sync_r <= 3'h7;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      mode_r     <= mode_nxt;
      count_r    <= count_nxt;
      reload_r   <= reload_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      ovf_tick_r <= ovf_tick_nxt;
      clkout_r   <= clkout_nxt;
      dir_sync_r <= dir_sync_nxt;
    end
  end

  // Read data is combinational from registers so a zero-wait access returns it.
  assign o_prdata = prdata_nxt;

  assign o_rx_baud_tick = ctrl_r[`TMR2_BIT_RXSEL] ? ovf_tick_r : i_timer1_overflow; // R4
  assign o_tx_baud_tick = ctrl_r[`TMR2_BIT_TXSEL] ? ovf_tick_r : i_timer1_overflow; // R5

  assign o_count_pin_out = clkout_r;
  assign o_count_pin_oe  = mode_r[`TMR2_BIT_CLKOUT];

  assign o_timer_irq = ctrl_r[`TMR2_BIT_OVF] | (ctrl_r[`TMR2_BIT_EXF] & ~mode_r[`TMR2_BIT_UPDOWN]); // R3
  assign o_irq       = |(irq_stat_r & irq_mask_r);
endmodule

// ---- pkg/tmr2_pkg.sv ----
package tmr2_pkg;
  typedef enum logic [1:0]
  {
    TMR2_ACT_NONE    = 2'b00,
    TMR2_ACT_RELOAD  = 2'b01,
    TMR2_ACT_CAPTURE = 2'b10
  } tmr2_action_t;
endpackage

// ---- pkg/tmr2_regs.svh ----
`ifndef TMR2_REGS_SVH
`define TMR2_REGS_SVH
// Byte addresses on the APB; TMR2_ADDR_MODE is the document's C9h address and is not decoded.
`define TMR2_ADDR_CONTROL    12'h000
`define TMR2_ADDR_MODE       12'h0c9
`define TMR2_ADDR_MODE_BYTE  12'h324
`define TMR2_ADDR_COUNT      12'h008
`define TMR2_ADDR_RELOAD     12'h00c
`define TMR2_ADDR_IRQ_STATUS 12'h010
`define TMR2_ADDR_IRQ_MASK   12'h014
// Control register fields.
`define TMR2_BIT_OVF       7
`define TMR2_BIT_EXF       6
`define TMR2_BIT_RXSEL     5
`define TMR2_BIT_TXSEL     4
`define TMR2_BIT_TRIGEN    3
`define TMR2_BIT_RUN       2
`define TMR2_BIT_SRC       1
`define TMR2_BIT_CAPREL    0
// Mode control fields.
`define TMR2_BIT_CLKOUT    1
`define TMR2_BIT_UPDOWN    0
// Interrupt status fields.
`define TMR2_IRQ_OVF       0
`define TMR2_IRQ_EXF       1
`define TMR2_IRQ_CAPTURE   2
// Reset values.
`define TMR2_CONTROL_RESET 8'h00
`define TMR2_MODE_RESET    2'h0
`endif

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`include "tmr2_regs.svh"
module tb;
  localparam logic [11:0] a_ctl = `TMR2_ADDR_CONTROL;
  localparam logic [11:0] a_mod = `TMR2_ADDR_MODE_BYTE;
  localparam logic [11:0] a_cnt = `TMR2_ADDR_COUNT;
  localparam logic [11:0] a_rld = `TMR2_ADDR_RELOAD;
  localparam logic [11:0] a_sts = `TMR2_ADDR_IRQ_STATUS;
  localparam logic [11:0] a_msk = `TMR2_ADDR_IRQ_MASK;
  logic i_mclk = 0, i_reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, o_prdata, rdat, snap;
  logic o_pready, o_pslverr, serr, rdy, cnt_pin, trig_pin, t1_ovf, o_timer_irq, o_irq, rx_t, tx_t, oe, cko;
  int failures = 0, n_checks = 0, rx_n = 0, tx_n = 0, rx0, tx0;
  initial forever #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) rx_n <= rx_n + rx_t;
  always @(posedge i_mclk) tx_n <= tx_n + tx_t;
  tmr2_pins_model m (.i_mclk(i_mclk), .o_count_pin(cnt_pin), .o_trigger_pin(trig_pin), .o_timer1_overflow(t1_ovf));
  tmr2_timer dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_count_pin(cnt_pin), .i_trigger_pin(trig_pin), .o_count_pin_out(cko),
    .o_count_pin_oe(oe), .i_timer1_overflow(t1_ovf), .o_rx_baud_tick(rx_t), .o_tx_baud_tick(tx_t),
    .o_timer_irq(o_timer_irq), .o_irq(o_irq));
  task end_of_test();
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    n_checks++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      failures++;
    end
  endtask
  // Read data is taken at the completing edge, before that edge's updates land.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1;
    for (k = 0; k < 8; k++)
    begin
      @(posedge i_mclk);
      rdy = o_pready;
      rdat = o_prdata;
      serr = o_pslverr;
      if (rdy === 1'b1) break;
    end
    psel <= 0;
    penable <= 0;
    @(negedge i_mclk);
    if (k == 8) begin failures++; end_of_test(); end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    xfer(0, a, 0);
    chk(rdat, e, nm);
  endtask
  task ticks(input int n);
    @(negedge i_mclk);
    rx0 = rx_n;
    tx0 = tx_n;
    repeat (40) @(negedge i_mclk);
    chk(rx_n - rx0, n, "rx ticks");
    chk(tx_n - tx0, n, "tx ticks");
  endtask
  initial
  begin
    int k;
    repeat (12) @(posedge i_mclk);
    i_reset_n <= 1;
    rdc(a_ctl, 0, "ctrl reset");
    rdc(a_mod, 0, "mode reset");
    xfer(0, 12'h100, 0);
    chk(serr, 1, "slverr");
    chk(rdat, 0, "unmapped");
    xfer(1, a_mod, 32'hff);
    rdc(a_mod, 32'h3, "mode bits");
    xfer(1, a_mod, 0);
    ticks(5);
    xfer(1, a_rld, 32'hfff0);
    xfer(1, a_cnt, 32'hfff0);
    xfer(1, a_msk, 32'h1);
    xfer(1, a_ctl, 32'h04);
    for (k = 0; k < 2000 && o_timer_irq !== 1'b1; k++) @(posedge i_mclk);
    if (k == 2000) begin failures++; end_of_test(); end
    xfer(1, a_ctl, 32'h80);
    rdc(a_ctl, 32'h80, "ovf flag");
    chk(o_irq, 1, "irq");
    rdc(a_sts, 32'h1, "status");
    chk(o_irq, 0, "irq cleared");
    xfer(0, a_cnt, 0);
    snap = rdat;
    chk(rdat[31:4], 28'hfff, "reloaded");
    repeat (30) @(posedge i_mclk);
    rdc(a_cnt, snap, "stopped");
    xfer(1, a_ctl, 0);
    chk(o_timer_irq, 0, "flag clear");
    xfer(1, a_cnt, 32'h1234);
    xfer(1, a_ctl, 32'h09);
    m.pulse_low(1);
    rdc(a_rld, 32'h1234, "capture");
    rdc(a_ctl, 32'h49, "event flag");
    chk(o_timer_irq, 1, "event irq");
    xfer(1, a_mod, 32'h1);
    chk(o_timer_irq, 0, "updown irq");
    xfer(1, a_mod, 0);
    xfer(1, a_rld, 32'h55);
    xfer(1, a_ctl, 32'h08);
    m.pulse_low(1);
    rdc(a_cnt, 32'h55, "trig reload");
    rdc(a_ctl, 32'h48, "reload flag");
    xfer(1, a_ctl, 32'h38);
    xfer(1, a_cnt, 32'h7);
    m.pulse_low(1);
    rdc(a_cnt, 32'h7, "baud trig");
    rdc(a_ctl, 32'h38, "no flag");
    xfer(1, a_ctl, 32'h30);
    ticks(0);
    xfer(1, a_cnt, 32'hfffc);
    xfer(1, a_ctl, 32'h34);
    repeat (400) @(posedge i_mclk);
    rdc(a_ctl, 32'h34, "no ovf flag");
    chk(rx_n > rx0 && tx_n > tx0, 1, "own ticks");
    xfer(1, a_ctl, 0);
    xfer(1, a_mod, 32'h2);
    chk(oe, 1, "clock out oe");
    xfer(1, a_cnt, 32'hffff);
    xfer(1, a_ctl, 32'h04);
    xfer(1, a_ctl, 0);
    chk(cko, 1, "clock out toggle");
    xfer(1, a_mod, 0);
    chk(oe, 0, "clock out off");
    xfer(1, a_cnt, 0);
    xfer(1, a_ctl, 32'h06);
    repeat (3) m.pulse_low(0);
    rdc(a_cnt, 32'h3, "pin count");
    xfer(1, a_msk, 0);
    chk(o_irq, 0, "masked");
    end_of_test();
  end
endmodule

// ---- verif/tmr2_pins_model.sv ----
`timescale 1ns/1ns
// Far side: the count and trigger pins idle high, and timer 1 ticks every eight cycles.
module tmr2_pins_model
(
  // Clock
  input  wire logic i_mclk,
  // Pins and timer 1
  output logic      o_count_pin,
  output logic      o_trigger_pin,
  output logic      o_timer1_overflow
);
  int ph = 0;
  initial
  begin
    o_count_pin = 1'b1;
    o_trigger_pin = 1'b1;
    o_timer1_overflow = 1'b0;
  end
  always @(posedge i_mclk)
  begin
    ph <= ph + 1;
    o_timer1_overflow <= (ph % 8 == 7);
  end
  // Each low level lasts six cycles so that the sampler sees it.
  task automatic pulse_low(input bit trig);
    @(posedge i_mclk);
    if (trig) o_trigger_pin <= 1'b0;
    else o_count_pin <= 1'b0;
    repeat (6) @(posedge i_mclk);
    o_trigger_pin <= 1'b1;
    o_count_pin <= 1'b1;
    repeat (6) @(posedge i_mclk);
  endtask
endmodule

// ---- verif/tmr2_timer_asserts.sv ----
`timescale 1ns/1ns
`include "tmr2_regs.svh"
module tmr2_timer_asserts
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // Bus
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] o_prdata,
  input  wire logic        o_pready,
  input  wire logic        o_pslverr,
  // Outputs
  input  wire logic        o_count_pin_oe,
  input  wire logic        o_timer_irq,
  input  wire logic        o_irq
);
  logic acc;
  logic mapped;
  assign acc = i_psel & i_penable;
  assign mapped = i_paddr inside {`TMR2_ADDR_CONTROL, `TMR2_ADDR_MODE_BYTE, `TMR2_ADDR_COUNT,
    `TMR2_ADDR_RELOAD, `TMR2_ADDR_IRQ_STATUS, `TMR2_ADDR_IRQ_MASK};
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence acc_s;
    i_psel && i_penable;
  endsequence
  ready_a: assert property (o_pready) else $error("pready low");
  slverr_a: assert property (acc_s |-> o_pslverr == !mapped) else $error("pslverr wrong");
  unmapped_a: assert property (acc_s ##0 (!mapped && !i_pwrite) |-> o_prdata == 32'h0) else $error("unmapped data");
  mode_rsv_a: assert property (acc_s ##0 (!i_pwrite && i_paddr == `TMR2_ADDR_MODE_BYTE) |->
    o_prdata[31:2] == 30'h0) else $error("mode upper bits");
  ctl_rsv_a: assert property (acc_s ##0 (!i_pwrite && i_paddr == `TMR2_ADDR_CONTROL) |->
    o_prdata[31:8] == 24'h0) else $error("control upper bits");
  tirq_clr_a: assert property ($fell(o_timer_irq) |-> $past(acc && i_pwrite &&
    (i_paddr == `TMR2_ADDR_CONTROL || i_paddr == `TMR2_ADDR_MODE_BYTE))) else $error("timer irq dropped");
  irq_clr_a: assert property ($fell(o_irq) |-> $past(acc && (i_pwrite ? i_paddr == `TMR2_ADDR_IRQ_MASK :
    i_paddr == `TMR2_ADDR_IRQ_STATUS))) else $error("irq dropped");
  oe_wr_a: assert property ($changed(o_count_pin_oe) |-> $past(acc && i_pwrite &&
    i_paddr == `TMR2_ADDR_MODE_BYTE)) else $error("oe changed");
endmodule
bind tmr2_timer tmr2_timer_asserts u_chk (.i_mclk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .o_count_pin_oe, .o_timer_irq, .o_irq);
